// *** rtl/khcp_defs.vh ***
`ifndef KHCP_DEFS_VH
`define KHCP_DEFS_VH

// Bus addressing
`define KHCP_SLAVE_ADDR     7'h51
`define KHCP_DIR_READ       1'b1
`define KHCP_BITS_PER_BYTE  4'h8

// Opcodes
`define KHCP_OP_READ_CAUSE  8'hD0
`define KHCP_OP_PIN_EVT_EN  8'hD1
`define KHCP_OP_READ_STAT   8'hE0
`define KHCP_OP_READ_FAULT  8'hF0

// Cause code fields
`define KHCP_CAUSE_ERR      3
`define KHCP_CAUSE_PIN1     2
`define KHCP_CAUSE_PIN0     1
`define KHCP_CAUSE_KEY      0
`define KHCP_CAUSE_USED     8'h0F

// Fault code fields
`define KHCP_FLT_QUEUE_OVF  6
`define KHCP_FLT_LOST_REQ   4
`define KHCP_FLT_MULTI_KEY  2
`define KHCP_FLT_BAD_OP     1
`define KHCP_FLT_OVERRUN    0
`define KHCP_FLT_USED       8'h57

// Outcome codes
`define KHCP_STAT_RESET     8'h00
`define KHCP_STAT_PIN_WAKE  8'h02
`define KHCP_STAT_OK        8'h06
`define KHCP_STAT_FAIL      8'h15

`define KHCP_ZERO8          8'h00
`define KHCP_EN_RESET       2'h0

`endif

// *** rtl/khcp_sync.v ***
`timescale 1ns/10ps
module khcp_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             core_clk_i,
   input  wire             reset_n_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] stable_r;

   // Pins idle high on an open-drain bus
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_r   <= {WIDTH{1'b1}};
         stable_r <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_r   <= async_i;
         stable_r <= meta_r;
      end
   end

   assign sync_o = stable_r;

endmodule // khcp_sync

// *** rtl/khcp_bus_cond.v ***
`timescale 1ns/10ps
module khcp_bus_cond
(
   input  wire core_clk_i,
   input  wire reset_n_i,
   input  wire scl_s_i,
   input  wire sda_s_i,
   output wire scl_rise_o,
   output wire scl_fall_o,
   output wire start_o,
   output wire stop_o
);

   reg scl_d_r;
   reg sda_d_r;

   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         scl_d_r <= scl_s_i;
         sda_d_r <= sda_s_i;
      end
   end

   assign scl_rise_o = scl_s_i & ~scl_d_r;
   assign scl_fall_o = ~scl_s_i & scl_d_r;
   // Data changing while the clock is high marks a frame boundary
   assign start_o    = scl_s_i & scl_d_r & sda_d_r & ~sda_s_i;
   assign stop_o     = scl_s_i & scl_d_r & ~sda_d_r & sda_s_i;

endmodule // khcp_bus_cond

// *** rtl/khcp_cmd_port.v ***
`timescale 1ns/10ps
`include "khcp_defs.vh"
module khcp_cmd_port
(
   input  wire       core_clk_i,
   input  wire       reset_n_i,
   input  wire       scl_i,
   output wire       scl_o,
   output wire       scl_oe_o,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_o,
   output wire       attn_n_o,
   input  wire       aux_pin_zero_i,
   input  wire       aux_pin_one_i,
   input  wire       key_event_i,
   input  wire       queue_full_i,
   input  wire       multi_key_i,
   input  wire       lost_request_i,
   input  wire       busy_i,
   input  wire       halt_req_i,
   output wire [1:0] pin_event_enable_o,
   output wire       asleep_o
);

   //------------------------------------------------------------
   // Pin sampling
   //------------------------------------------------------------
   wire [3:0] sync_w;
   wire       scl_s;
   wire       sda_s;
   wire       pin0_s;
   wire       pin1_s;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_det;
   wire       stop_det;

   khcp_sync #(.WIDTH(4)) u_sync
   (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .async_i    ({aux_pin_one_i, aux_pin_zero_i, sda_i, scl_i}),
      .sync_o     (sync_w)
   );

   assign scl_s  = sync_w[0];
   assign sda_s  = sync_w[1];
   assign pin0_s = sync_w[2];
   assign pin1_s = sync_w[3];

   khcp_bus_cond u_cond
   (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .scl_s_i    (scl_s),
      .sda_s_i    (sda_s),
      .scl_rise_o (scl_rise),
      .scl_fall_o (scl_fall),
      .start_o    (start_det),
      .stop_o     (stop_det)
   );

   //------------------------------------------------------------
   // Bus state machine
   //------------------------------------------------------------
   localparam ST_IDLE   = 3'd0;
   localparam ST_ADDR   = 3'd1;
   localparam ST_ACK    = 3'd2;
   localparam ST_RX     = 3'd3;
   localparam ST_TX     = 3'd4;
   localparam ST_TX_ACK = 3'd5;

   reg [2:0] state_r,     state_nxt;
   reg [3:0] cnt_r,       cnt_nxt;
   reg [7:0] shift_r,     shift_nxt;
   reg [7:0] tx_r,        tx_nxt;
   reg       dir_r,       dir_nxt;
   reg       first_r,     first_nxt;
   reg       data_cnt_r,  data_cnt_nxt;
   reg [7:0] cmd_r,       cmd_nxt;
   reg       sleep_r,     sleep_nxt;
   reg       nack_once_r, nack_once_nxt;
   reg       sda_oe_r;
   reg       scl_oe_r,    scl_oe_nxt;
   reg [1:0] en_r,        en_nxt;
   reg [7:0] cause_r,     cause_nxt;
   reg [7:0] fault_r,     fault_nxt;
   reg [7:0] stat_r,      stat_nxt;
   reg       pin0_d_r;
   reg       pin1_d_r;

   reg       rd_cause;
   reg       rd_fault;
   reg [7:0] read_val;
   reg [7:0] cause_set;
   reg [7:0] fault_set;
   reg       pin0_edge;
   reg       pin1_edge;
   reg       sda_drive;

   always @*
   begin
      case (cmd_r)
         `KHCP_OP_READ_CAUSE: read_val = cause_r;
         `KHCP_OP_READ_STAT:  read_val = stat_r;
         `KHCP_OP_READ_FAULT: read_val = fault_r;
         default:             read_val = `KHCP_ZERO8;
      endcase
   end

   always @*
   begin
      state_nxt     = state_r;
      cnt_nxt       = cnt_r;
      shift_nxt     = shift_r;
      tx_nxt        = tx_r;
      dir_nxt       = dir_r;
      first_nxt     = first_r;
      data_cnt_nxt  = data_cnt_r;
      cmd_nxt       = cmd_r;
      sleep_nxt     = sleep_r;
      nack_once_nxt = nack_once_r;
      en_nxt        = en_r;
      stat_nxt      = stat_r;
      rd_cause      = 1'b0;
      rd_fault      = 1'b0;
      cause_set     = `KHCP_ZERO8;
      fault_set     = `KHCP_ZERO8;

      // Pin edges, one enabled pin reports on both bits
      pin0_edge = en_r[0] & (pin0_s ^ pin0_d_r);
      pin1_edge = en_r[1] & (pin1_s ^ pin1_d_r);
      if (pin0_edge | pin1_edge)
      begin
         if (en_r == 2'b11)
         begin
            cause_set[`KHCP_CAUSE_PIN0] = pin0_edge;
            cause_set[`KHCP_CAUSE_PIN1] = pin1_edge;
         end
         else
         begin
            cause_set[`KHCP_CAUSE_PIN0] = 1'b1;
            cause_set[`KHCP_CAUSE_PIN1] = 1'b1;
         end
         if (sleep_r)
         begin
            sleep_nxt = 1'b0;
            stat_nxt  = `KHCP_STAT_PIN_WAKE;
         end
      end
      cause_set[`KHCP_CAUSE_KEY] = key_event_i;
      fault_set[`KHCP_FLT_QUEUE_OVF] = key_event_i & queue_full_i;
      fault_set[`KHCP_FLT_LOST_REQ]  = lost_request_i;
      fault_set[`KHCP_FLT_MULTI_KEY] = multi_key_i;

      // Wake on any bus activity and refuse the next address
      if (sleep_r & (start_det | scl_fall))
      begin
         sleep_nxt     = 1'b0;
         nack_once_nxt = 1'b1;
      end
      else if (halt_req_i & ~sleep_r & (state_r == ST_IDLE))
         sleep_nxt = 1'b1;

      if (start_det)
      begin
         state_nxt = ST_ADDR;
         cnt_nxt   = 4'd0;
      end
      else if (stop_det)
         state_nxt = ST_IDLE;
      else
      begin
         case (state_r)
            ST_IDLE:
            begin
               state_nxt = ST_IDLE;
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  cnt_nxt   = cnt_r + 4'd1;
               end
               else if (scl_fall & (cnt_r == `KHCP_BITS_PER_BYTE))
               begin
                  if ((shift_r[7:1] == `KHCP_SLAVE_ADDR) & ~nack_once_r & ~sleep_r)
                  begin
                     state_nxt = ST_ACK;
                     dir_nxt   = shift_r[0];
                     if (shift_r[0] != `KHCP_DIR_READ)
                     begin
                        first_nxt    = 1'b1;
                        data_cnt_nxt = 1'b0;
                     end
                  end
                  else
                  begin
                     state_nxt     = ST_IDLE;
                     nack_once_nxt = 1'b0;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_nxt = 4'd0;
                  if (dir_r == `KHCP_DIR_READ)
                  begin
                     state_nxt = ST_TX;
                     tx_nxt    = read_val;
                  end
                  else
                     state_nxt = ST_RX;
               end
            end
            ST_RX:
            begin
               if (scl_rise)
               begin
                  shift_nxt = {shift_r[6:0], sda_s};
                  cnt_nxt   = cnt_r + 4'd1;
               end
               else if (scl_fall & (cnt_r == `KHCP_BITS_PER_BYTE))
               begin
                  state_nxt = ST_ACK;
                  first_nxt = 1'b0;
                  if (first_r)
                  begin
                     cmd_nxt = shift_r;
                     case (shift_r)
                        // Reading the outcome must not overwrite it
                        `KHCP_OP_READ_STAT:
                           stat_nxt = stat_r;
                        `KHCP_OP_READ_CAUSE, `KHCP_OP_READ_FAULT, `KHCP_OP_PIN_EVT_EN:
                           stat_nxt = `KHCP_STAT_OK;
                        default:
                        begin
                           fault_set[`KHCP_FLT_BAD_OP] = 1'b1;
                           stat_nxt = `KHCP_STAT_FAIL;
                        end
                     endcase
                  end
                  else if ((cmd_r == `KHCP_OP_PIN_EVT_EN) & ~data_cnt_r)
                  begin
                     en_nxt       = shift_r[1:0];
                     data_cnt_nxt = 1'b1;
                  end
                  else
                  begin
                     fault_set[`KHCP_FLT_OVERRUN] = 1'b1;
                     stat_nxt = `KHCP_STAT_FAIL;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_rise)
                  cnt_nxt = cnt_r + 4'd1;
               else if (scl_fall)
               begin
                  if (cnt_r == `KHCP_BITS_PER_BYTE)
                  begin
                     state_nxt = ST_TX_ACK;
                     rd_cause  = (cmd_r == `KHCP_OP_READ_CAUSE);
                     rd_fault  = (cmd_r == `KHCP_OP_READ_FAULT);
                  end
                  else
                     tx_nxt = {tx_r[6:0], 1'b0};
               end
            end
            ST_TX_ACK:
            begin
               // Host acknowledge: keep off the line, resend on the next fall
               if (scl_rise & sda_s)
                  state_nxt = ST_IDLE;
               else if (scl_fall)
               begin
                  state_nxt = ST_TX;
                  cnt_nxt   = 4'd0;
                  tx_nxt    = read_val;
               end
            end
            default:
               state_nxt = ST_IDLE;
         endcase
      end

      // Stretch the clock low while the core is busy
      if (scl_fall & busy_i & (state_r != ST_IDLE))
         scl_oe_nxt = 1'b1;
      else if (~busy_i)
         scl_oe_nxt = 1'b0;
      else
         scl_oe_nxt = scl_oe_r;

      // Set wins over the clearing read
      fault_nxt = ((rd_fault ? `KHCP_ZERO8 : fault_r) | fault_set) & `KHCP_FLT_USED;
      cause_nxt = (rd_cause ? `KHCP_ZERO8 : cause_r) | cause_set;
      if (rd_fault & (fault_set == `KHCP_ZERO8))
         cause_nxt[`KHCP_CAUSE_ERR] = 1'b0;
      if (fault_set != `KHCP_ZERO8)
         cause_nxt[`KHCP_CAUSE_ERR] = 1'b1;
      cause_nxt = cause_nxt & `KHCP_CAUSE_USED;

      sda_drive = (state_nxt == ST_ACK) | ((state_nxt == ST_TX) & ~tx_nxt[7]);
   end

   //------------------------------------------------------------
   // Registers
   //------------------------------------------------------------
   always @(posedge core_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_r     <= ST_IDLE;
         cnt_r       <= 4'd0;
         shift_r     <= `KHCP_ZERO8;
         tx_r        <= `KHCP_ZERO8;
         dir_r       <= 1'b0;
         first_r     <= 1'b0;
         data_cnt_r  <= 1'b0;
         cmd_r       <= `KHCP_ZERO8;
         sleep_r     <= 1'b0;
         nack_once_r <= 1'b0;
         sda_oe_r    <= 1'b0;
         scl_oe_r    <= 1'b0;
         en_r        <= `KHCP_EN_RESET;
         cause_r     <= `KHCP_ZERO8;
         fault_r     <= `KHCP_ZERO8;
         stat_r      <= `KHCP_STAT_RESET;
         pin0_d_r    <= 1'b1;
         pin1_d_r    <= 1'b1;
      end
      else
      begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_nxt;
         shift_r     <= shift_nxt;
         tx_r        <= tx_nxt;
         dir_r       <= dir_nxt;
         first_r     <= first_nxt;
         data_cnt_r  <= data_cnt_nxt;
         cmd_r       <= cmd_nxt;
         sleep_r     <= sleep_nxt;
         nack_once_r <= nack_once_nxt;
         sda_oe_r    <= sda_drive;
         scl_oe_r    <= scl_oe_nxt;
         en_r        <= en_nxt;
         cause_r     <= cause_nxt;
         fault_r     <= fault_nxt;
         stat_r      <= stat_nxt;
         pin0_d_r    <= pin0_s;
         pin1_d_r    <= pin1_s;
      end
   end

   assign scl_o              = 1'b0;
   assign sda_o              = 1'b0;
   assign scl_oe_o           = scl_oe_r;
   assign sda_oe_o           = sda_oe_r;
   assign attn_n_o           = ~(|cause_r);
   assign pin_event_enable_o = en_r;
   assign asleep_o           = sleep_r;

endmodule // khcp_cmd_port

// *** testbench/khcp_cmd_port_asserts.sv ***
`timescale 1ns/10ps
module khcp_cmd_port_chk
(
   input wire       core_clk_i,
   input wire       reset_n_i,
   input wire       scl_i,
   input wire       scl_o,
   input wire       scl_oe_o,
   input wire       sda_o,
   input wire       sda_oe_o,
   input wire       attn_n_o,
   input wire       aux_pin_zero_i,
   input wire       key_event_i,
   input wire       busy_i,
   input wire [1:0] pin_event_enable_o,
   input wire       asleep_o
);
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // ----------
   // Bus and attention checks
   // ----------
   a_key_attn_low: assert property (key_event_i |-> ##[1:4] !attn_n_o)
      else $error("attention not raised after key event");
   a_attn_rel_scl: assert property ($rose(attn_n_o) |-> !scl_i)
      else $error("attention released outside a bus clock low");
   a_stretch_busy: assert property ($rose(scl_oe_o) |-> $past(busy_i) && !scl_i)
      else $error("clock stretch without busy core");
   a_stretch_end: assert property (!busy_i [*3] |-> !scl_oe_o)
      else $error("clock held after core idle");
   a_enable_scl_low: assert property (!$stable(pin_event_enable_o) |-> !scl_i)
      else $error("pin enables changed while bus clock high");
   a_wake_no_ack: assert property ($fell(asleep_o) |-> !sda_oe_o [*8])
      else $error("data pulled low right after wake");
   a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("open drain pin driven high");
   a_ack_scl_low: assert property ($rose(sda_oe_o) |-> !scl_i)
      else $error("data pulled low while bus clock high");
   a_pin_attn: assert property ((pin_event_enable_o[0] && aux_pin_zero_i != $past(aux_pin_zero_i))
                                |-> ##[1:8] !attn_n_o)
      else $error("pin edge gave no attention");
   a_reset_quiet: assert property ($rose(reset_n_i) |-> attn_n_o && !sda_oe_o && !scl_oe_o)
      else $error("bus or attention active after reset");
   c_key: cover property (key_event_i ##[1:4] !attn_n_o);
   c_stretch: cover property ($rose(scl_oe_o));
   c_wake: cover property ($fell(asleep_o));
endmodule // khcp_cmd_port_chk

bind khcp_cmd_port khcp_cmd_port_chk i_khcp_cmd_port_chk (.core_clk_i, .reset_n_i, .scl_i, .scl_o, .scl_oe_o,
   .sda_o, .sda_oe_o, .attn_n_o, .aux_pin_zero_i, .key_event_i, .busy_i, .pin_event_enable_o, .asleep_o);

// *** testbench/khcp_host_model.sv ***
`timescale 1ns/10ps
module khcp_host_model
(
   input  wire logic core_clk_i,
   input  wire logic scl_oe_i,
   input  wire logic sda_oe_i,
   output wire logic scl_o,
   output wire logic sda_o
);
   logic scl_m = 1'b1;
   logic sda_m = 1'b1;
   int   n;

   // ----------
   // Pulled-up open drain lines
   // ----------
   assign scl_o = scl_m & ~scl_oe_i;
   assign sda_o = sda_m & ~sda_oe_i;

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask

   // Data edge while clock high: start (1 to 0) or stop (0 to 1)
   task automatic cond(input logic a, input logic b);
      tick(1);
      scl_m <= 1'b0;
      tick(2);
      sda_m <= a;
      tick(6);
      scl_m <= 1'b1;
      tick(4);
      sda_m <= b;
      tick(4);
   endtask
   task automatic m_start();
      cond(1'b1, 1'b0);
   endtask
   task automatic m_stop();
      cond(1'b0, 1'b1);
   endtask

   // Five cycles low, three high: one bit each 400 ns
   task automatic m_bit(input logic b, output logic r);
      tick(1);
      scl_m <= 1'b0;
      tick(2);
      sda_m <= b;
      tick(3);
      scl_m <= 1'b1;
      n = 0;
      tick(1);
      while (!scl_o && n < 4000)
      begin
         tick(1);
         n++;
      end
      tick(1);
      r = sda_o;
   endtask
   task automatic m_put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         m_bit(b[i], r);
      m_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic m_get(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         m_bit(1'b1, d[i]);
      m_bit(nack, r);
   endtask
endmodule // khcp_host_model

// *** testbench/khcp_cmd_port_tb.sv ***
`timescale 1ns/10ps
module khcp_cmd_port_tb;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        aux0 = 1'b0, aux1 = 1'b0, key_ev = 1'b0, q_full = 1'b0;
   logic        multi = 1'b0, lost = 1'b0, busy = 1'b0, halt = 1'b0;
   logic [7:0]  v;
   logic        ak;
   wire         scl_w, sda_w, scl_oe, sda_oe, attn_n, asleep;
   wire  [1:0]  pin_en;
   int          bad_count = 0, n_compared = 0, stretch = 0;
   // Stimulus, opcode, expected byte
   logic [19:0] rows [10] = '{20'h8_D001, 20'h0_D000, 20'h2_F004, 20'h0_D000, 20'h1_D008,
                              20'h0_F010, 20'hC_D009, 20'h0_F040, 20'h0_F000, 20'h0_E006};

   always #25 core_clk = ~core_clk;
   always @(posedge core_clk)
      if (scl_oe)
         stretch <= stretch + 1;

   khcp_cmd_port i_khcp_cmd_port
   (
      .core_clk_i(core_clk), .reset_n_i(reset_n), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .attn_n_o(attn_n), .aux_pin_zero_i(aux0),
      .aux_pin_one_i(aux1), .key_event_i(key_ev), .queue_full_i(q_full), .multi_key_i(multi),
      .lost_request_i(lost), .busy_i(busy), .halt_req_i(halt), .pin_event_enable_o(pin_en),
      .asleep_o(asleep)
   );
   khcp_host_model i_khcp_host_model
   (
      .core_clk_i(core_clk), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl_w), .sda_o(sda_w)
   );

   // ----------
   // Helpers
   // ----------
   task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("MISMATCH t=%0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic done(input string m);
      $display("test %s finished", m);
   endtask
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic pulse(input logic [3:0] s);
      @(posedge core_clk);
      {key_ev, q_full, multi, lost} <= s;
      @(posedge core_clk);
      {key_ev, q_full, multi, lost} <= 4'h0;
      repeat (8) @(posedge core_clk);
   endtask
   task automatic toggle(input logic k);
      @(posedge core_clk);
      if (k)
         aux1 <= ~aux1;
      else
         aux0 <= ~aux0;
      repeat (10) @(posedge core_clk);
   endtask
   task automatic snd(input logic [7:0] b, input logic e);
      i_khcp_host_model.m_put(b, ak);
      chk8({7'h00, ak}, {7'h00, e}, "acknowledge");
   endtask
   task automatic wr_cmd(input logic [7:0] op, input logic [15:0] d, input int nb);
      i_khcp_host_model.m_start();
      snd(8'hA2, 1'b1);
      snd(op, 1'b1);
      for (int i = 0; i < nb; i++)
         snd(d[15-8*i -: 8], 1'b1);
      i_khcp_host_model.m_stop();
   endtask
   task automatic rd_cmd(input logic [7:0] op, input logic [7:0] e, input string m);
      i_khcp_host_model.m_start();
      snd(8'hA2, 1'b1);
      snd(op, 1'b1);
      i_khcp_host_model.m_start();
      snd(8'hA3, 1'b1);
      i_khcp_host_model.m_get(1'b1, v);
      i_khcp_host_model.m_stop();
      chk8(v, e, m);
   endtask

   // ----------
   // Tests
   // ----------
   initial
   begin
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (int r = 0; r < 10; r++)
      begin
         pulse(rows[r][19:16]);
         if (rows[r][19:16] != 4'h0)
            chk8({7'h00, attn_n}, 8'h00, "attention low");
         rd_cmd(rows[r][15:8], rows[r][7:0], "row read");
         if (rows[r][15:8] == 8'hD0)
            chk8({7'h00, attn_n}, 8'h01, "attention high");
      end
      done("rows");
      wr_cmd(8'hD1, 16'h0100, 1);
      chk8({6'h00, pin_en}, 8'h01, "pin enables");
      toggle(1'b0);
      rd_cmd(8'hD0, 8'h06, "single pin");
      wr_cmd(8'hD1, 16'h0300, 1);
      toggle(1'b1);
      rd_cmd(8'hD0, 8'h04, "pin one");
      toggle(1'b0);
      rd_cmd(8'hD0, 8'h02, "pin zero");
      done("pins");
      wr_cmd(8'h55, 16'h0000, 0);
      rd_cmd(8'hE0, 8'h15, "failed outcome");
      rd_cmd(8'hD0, 8'h08, "bad opcode cause");
      rd_cmd(8'hF0, 8'h02, "bad opcode fault");
      wr_cmd(8'hD1, 16'h0000, 2);
      chk8({6'h00, pin_en}, 8'h00, "pin enables off");
      rd_cmd(8'hF0, 8'h01, "overrun fault");
      rd_cmd(8'hD0, 8'h00, "cause after fault read");
      i_khcp_host_model.m_start();
      snd(8'hA4, 1'b0);
      i_khcp_host_model.m_stop();
      done("errors");
      busy <= 1'b1;
      fork
         rd_cmd(8'hE0, 8'h06, "stretched status");
         begin
            repeat (150) @(posedge core_clk);
            busy <= 1'b0;
         end
      join
      chk8({7'h00, (stretch > 0)}, 8'h01, "stretch seen");
      i_khcp_host_model.m_start();
      snd(8'hA2, 1'b1);
      snd(8'hE0, 1'b1);
      i_khcp_host_model.m_start();
      snd(8'hA3, 1'b1);
      i_khcp_host_model.m_get(1'b0, v);
      chk8(v, 8'h06, "status first byte");
      i_khcp_host_model.m_get(1'b1, v);
      i_khcp_host_model.m_stop();
      chk8(v, 8'h06, "status repeated");
      done("stretch");
      for (int w = 0; w < 2; w++)
      begin
         @(posedge core_clk);
         halt <= 1'b1;
         repeat (8) @(posedge core_clk);
         halt <= 1'b0;
         chk8({7'h00, asleep}, 8'h01, "asleep");
         i_khcp_host_model.m_start();
         snd(w ? 8'h01 : 8'hA2, 1'b0);
         i_khcp_host_model.m_stop();
         chk8({7'h00, asleep}, 8'h00, "awake");
         rd_cmd(8'hE0, 8'h06, "retry");
      end
      done("sleep");
      wr_cmd(8'hD1, 16'h0300, 1);
      @(posedge core_clk);
      halt <= 1'b1;
      repeat (8) @(posedge core_clk);
      halt <= 1'b0;
      chk8({7'h00, asleep}, 8'h01, "asleep before pin");
      toggle(1'b0);
      chk8({7'h00, asleep}, 8'h00, "pin wake");
      rd_cmd(8'hE0, 8'h02, "pin wake outcome");
      done("pin wake");
      pulse(4'h8);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk8({2'h0, scl_oe, sda_oe, attn_n, asleep, pin_en}, 8'h08, "reset outputs");
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_cmd(8'hE0, 8'h00, "outcome after reset");
      rd_cmd(8'hD0, 8'h00, "cause after reset");
      done("reset");
      wrap_up();
   end

   initial
   begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      wrap_up();
   end
endmodule // khcp_cmd_port_tb
